// ### design/sbsp_pkg.sv
package sbsp_pkg;
   // ------------------------------------------------------------
   // Addresses
   // ------------------------------------------------------------
   localparam logic [6:0] SBSP_ADDR_DEFAULT = 7'h2E;
   localparam logic [4:0] SBSP_ADDR_SEL_HI = 5'h0B;
   localparam logic [7:0] SBSP_PTR_RST = 8'h00;
   localparam logic [7:0] SBSP_REG_RST = 8'h00;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int SBSP_CLK_MHZ = 125;
   localparam int SBSP_TIMEOUT_MS = 25;
   localparam int SBSP_TIMEOUT_CYC = SBSP_TIMEOUT_MS * 1000 * SBSP_CLK_MHZ;
   localparam int SBSP_BITS = 8;
   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      SBSP_IDLE = 6'b000001,
      SBSP_ADDR = 6'b000010,
      SBSP_ACK = 6'b000100,
      SBSP_RX = 6'b001000,
      SBSP_TX = 6'b010000,
      SBSP_MACK = 6'b100000
   } sbsp_state_t;
endpackage : sbsp_pkg

// ### design/sbsp_sync.sv
`timescale 1ns/1ps
module sbsp_sync (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic din,
   output logic dout
);
   logic meta_r;
   // ------------------------------------------------------------
   // Two stage synchroniser, first stage read only by the second
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         meta_r <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule : sbsp_sync

// ### design/sbsp_slave.sv
// Function
// R1: Strap high selects default address
// R2: Strap low selects address by select strap
// R3: Address latched on first valid transaction
// R4: Strap pins then return to fan roles
// R5: Detect start, then receive address
// R6: Shift eight bits, address MSB first
// R7: Acknowledge own address, else idle
// R8: Direction bit zero writes, one reads
// R9: Nine clocks per byte with acknowledge
// R10: SDA rise with SCL high is stop
// R11: Master ends write with stop
// R12: Master ends read with nack, stop
// R13: Direction fixed per operation
// R14: Write one or two bytes, read one
// R15: First written byte loads pointer
// R16: Second written byte stored at pointer
// R17: Read returns register at pointer
// R18: Repeated start begins new operation
// R19: Send byte loads pointer, both acked
// R20: Write byte acks all three bytes
// R21: Read after send byte uses new pointer
// R22: Select mode address is 01011 plus straps
// R23: Read byte protocol supported
// R24: Idle bus timeout releases SDA, disableable
// R25: Master nacks single read then stops
// R26: Pointer persists, never auto-increments
// R27: No acknowledge for foreign address
`timescale 1ns/1ps
module sbsp_slave import sbsp_pkg::*; #(
   parameter int NUM_REGS = 256,
   parameter int TIMEOUT_CYC = SBSP_TIMEOUT_CYC
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic strap_enable_in,
   input wire logic strap_select_in,
   input wire logic bus_timeout_disable,
   input wire logic fan3_drive_level,
   output logic fan3_drive_output,
   output logic fan3_drive_oe,
   output logic fan4_speed_sense,
   output logic [6:0] slave_addr,
   output logic addr_locked,
   output logic [7:0] reg_pointer,
   output logic wr_strobe,
   output logic [7:0] wr_data
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic scl_s;
   logic sda_s;
   logic scl_d_r;
   logic sda_d_r;
   logic strap_en_s;
   logic strap_sel_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   sbsp_state_t state_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic rd_dir_r;
   logic ack_drive_r;
   logic matched_r;
   logic [1:0] byte_cnt_r;
   logic [31:0] idle_cnt_r;
   logic timeout;
   logic [7:0] regs_r [NUM_REGS];

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // A byte ends at the SCL fall that follows its eighth rising edge
   function automatic logic byte_end(input logic fall,
      input logic [3:0] cnt);
      byte_end = fall && (cnt == 4'(SBSP_BITS));
   endfunction : byte_end

   function automatic logic [6:0] strap_addr(input logic en,
      input logic sel);
      if (en)
         strap_addr = SBSP_ADDR_DEFAULT; // [R1]
      else
         strap_addr = {SBSP_ADDR_SEL_HI, 1'b0, sel}; // [R2] [R22]
   endfunction : strap_addr

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   sbsp_sync u_scl (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .din(scl_in),
      .dout(scl_s)
   );
   sbsp_sync u_sda (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .din(sda_in),
      .dout(sda_s)
   );
   sbsp_sync u_sen (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .din(strap_enable_in),
      .dout(strap_en_s)
   );
   sbsp_sync u_ssl (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .din(strap_select_in),
      .dout(strap_sel_s)
   );

   // ------------------------------------------------------------
   // Edge and condition detect
   // ------------------------------------------------------------
   // Delay stages reset to the idle high level: no false edge after reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s; // [R5]
   assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s; // [R10]
   assign timeout = !bus_timeout_disable &&
      (idle_cnt_r >= 32'(TIMEOUT_CYC)); // [R24]

   // ------------------------------------------------------------
   // Address straps
   // ------------------------------------------------------------
   // Straps are followed until the first start; no start can match before
   // that, so the live value is what the first transaction compares with.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         slave_addr <= SBSP_ADDR_DEFAULT;
         addr_locked <= 1'b0;
      end else if (!addr_locked) begin
         slave_addr <= strap_addr(strap_en_s, strap_sel_s); // [R1] [R2]
         if (start_det) begin
            addr_locked <= 1'b1; // [R3]
         end
      end
   end

   // ------------------------------------------------------------
   // Fan pin roles
   // ------------------------------------------------------------
   // Fan drive stays released while the strap is being read.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         fan3_drive_output <= 1'b0;
         fan3_drive_oe <= 1'b0;
         fan4_speed_sense <= 1'b0;
      end else begin
         fan3_drive_output <= 1'b0;
         fan3_drive_oe <= addr_locked & ~fan3_drive_level; // [R4]
         // Select strap pin serves as the speed sense input once locked
         fan4_speed_sense <= addr_locked & strap_sel_s; // [R4]
      end
   end

   // ------------------------------------------------------------
   // Idle timer
   // ------------------------------------------------------------
   // Counts only inside a transaction, so a quiet idle bus never times out
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         idle_cnt_r <= '0;
      end else if (state_r == SBSP_IDLE || scl_rise || scl_fall ||
                   timeout) begin
         idle_cnt_r <= '0;
      end else begin
         idle_cnt_r <= idle_cnt_r + 32'd1;
      end
   end

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_r <= SBSP_IDLE;
         bit_cnt_r <= '0;
         shift_r <= '0;
         rd_dir_r <= 1'b0;
         ack_drive_r <= 1'b0;
         matched_r <= 1'b0;
         byte_cnt_r <= '0;
      end else if (start_det) begin
         // Start overrides every state, so a repeated start always restarts
         state_r <= SBSP_ADDR; // [R5] [R18]
         bit_cnt_r <= '0;
         byte_cnt_r <= '0;
         ack_drive_r <= 1'b0;
         matched_r <= 1'b0;
      end else if (stop_det || timeout) begin
         state_r <= SBSP_IDLE; // [R10] [R11] [R24]
         ack_drive_r <= 1'b0;
      end else begin
         case (state_r)
            SBSP_IDLE: begin
               ack_drive_r <= 1'b0;
            end
            SBSP_ADDR, SBSP_RX: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s}; // [R6]
                  bit_cnt_r <= bit_cnt_r + 4'd1;
               end else if (byte_end(scl_fall, bit_cnt_r)) begin
                  bit_cnt_r <= '0;
                  if (state_r == SBSP_ADDR) begin
                     if (shift_r[7:1] == slave_addr) begin
                        matched_r <= 1'b1;
                        rd_dir_r <= shift_r[0]; // [R8] [R13]
                        ack_drive_r <= 1'b1; // [R7]
                        state_r <= SBSP_ACK;
                     end else begin
                        state_r <= SBSP_IDLE; // [R27]
                     end
                  end else if (byte_cnt_r < 2'd2) begin
                     ack_drive_r <= 1'b1; // [R19] [R20]
                     byte_cnt_r <= byte_cnt_r + 2'd1;
                     state_r <= SBSP_ACK;
                  end else begin
                     state_r <= SBSP_IDLE; // [R14]
                  end
               end
            end
            SBSP_ACK: begin
               // Release on the falling edge ending the ninth clock [R9]
               if (scl_fall) begin
                  ack_drive_r <= 1'b0;
                  if (rd_dir_r && byte_cnt_r == 2'd0) begin
                     shift_r <= regs_r[reg_pointer]; // [R17] [R21] [R23]
                     byte_cnt_r <= 2'd1;
                     state_r <= SBSP_TX; // [R8]
                  end else if (rd_dir_r) begin
                     state_r <= SBSP_IDLE; // [R14]
                  end else begin
                     state_r <= SBSP_RX;
                  end
               end
            end
            SBSP_TX: begin
               if (scl_rise) begin
                  bit_cnt_r <= bit_cnt_r + 4'd1;
               end else if (scl_fall) begin
                  if (bit_cnt_r == 4'(SBSP_BITS)) begin
                     bit_cnt_r <= '0;
                     state_r <= SBSP_MACK;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                  end
               end
            end
            SBSP_MACK: begin
               // Only one byte is supplied; later clocks read as ones [R14]
               if (scl_fall) begin
                  state_r <= SBSP_IDLE; // [R25] [R12]
               end
            end
            default: state_r <= SBSP_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pointer and register store
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_pointer <= SBSP_PTR_RST;
         wr_strobe <= 1'b0;
         wr_data <= '0;
      end else begin
         wr_strobe <= 1'b0;
         // Only the byte right after the address loads the pointer
         if (state_r == SBSP_RX && !start_det && !stop_det &&
             byte_end(scl_fall, bit_cnt_r)) begin
            if (byte_cnt_r == 2'd0) begin
               reg_pointer <= shift_r; // [R15] [R19] [R26]
            end else if (byte_cnt_r == 2'd1) begin
               wr_strobe <= 1'b1; // [R16] [R20]
               wr_data <= shift_r;
            end
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         // One flip-flop row per register; the pointer decode selects it
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               regs_r[gi] <= SBSP_REG_RST;
            end else if (wr_strobe && reg_pointer == 8'(gi)) begin
               regs_r[gi] <= wr_data; // [R16]
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // SDA drive
   // ------------------------------------------------------------
   // Open drain: only ever pulls low; a one is released.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         if (start_det || stop_det || timeout) begin
            sda_oe <= 1'b0; // [R24]
         end else if (ack_drive_r && matched_r) begin
            sda_oe <= 1'b1; // [R7]
         end else if (state_r == SBSP_TX) begin
            // Last bit held past the SCL fall: a release while SCL is
            // high would put a stop on the bus [R10]
            sda_oe <= ~shift_r[7]; // [R17]
         end else begin
            sda_oe <= 1'b0;
         end
      end
   end
endmodule : sbsp_slave

// ### test/sbsp_slave_chk.sv
`timescale 1ns/1ps
module sbsp_slave_chk (
   input logic ref_clk,
   input logic reset_n,
   input logic scl_in,
   input logic sda_out,
   input logic sda_oe,
   input logic fan3_drive_level,
   input logic fan3_drive_output,
   input logic fan3_drive_oe,
   input logic fan4_speed_sense,
   input logic [6:0] slave_addr,
   input logic addr_locked,
   input logic [7:0] reg_pointer,
   input logic wr_strobe
);
   // ------------------------------------------------------------
   // Port relations
   // ------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_fan_req;
      (addr_locked && !fan3_drive_level) [*3];
   endsequence
   sequence s_ack_rise;
      $rose(sda_oe);
   endsequence
   property p_fan_gate; s_fan_req |-> fan3_drive_oe; endproperty
   property p_unlocked;
      !addr_locked |-> !sda_oe && !fan3_drive_oe && !fan4_speed_sense;
   endproperty
   property p_lock_hold;
      addr_locked |=> addr_locked && $stable(slave_addr);
   endproperty
   property p_lock_start; $rose(addr_locked) |-> scl_in; endproperty
   property p_strobe; wr_strobe |=> !wr_strobe; endproperty
   property p_ptr; wr_strobe |-> $stable(reg_pointer); endproperty
   property p_low_drive;
      sda_out == 1'b0 && fan3_drive_output == 1'b0;
   endproperty
   // Open drain: the wire may only move while SCL is low
   property p_oe_rise; s_ack_rise |-> !scl_in; endproperty
   property p_oe_fall; $fell(sda_oe) |-> !scl_in; endproperty
   a_fan_gate: assert property (p_fan_gate) else $error("fan3 idle");
   a_unlocked: assert property (p_unlocked) else $error("early drive");
   a_lock_hold: assert property (p_lock_hold) else $error("addr moved");
   a_lock_start: assert property (p_lock_start) else $error("lock");
   a_strobe: assert property (p_strobe) else $error("long strobe");
   a_ptr: assert property (p_ptr) else $error("pointer moved");
   a_low_drive: assert property (p_low_drive) else $error("drive");
   a_oe_rise: assert property (p_oe_rise) else $error("sda rise");
   a_oe_fall: assert property (p_oe_fall) else $error("sda fall");
endmodule : sbsp_slave_chk
bind sbsp_slave sbsp_slave_chk u_sbsp_slave_chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .fan3_drive_level(fan3_drive_level),
   .fan3_drive_output(fan3_drive_output), .fan3_drive_oe(fan3_drive_oe),
   .fan4_speed_sense(fan4_speed_sense), .slave_addr(slave_addr),
   .addr_locked(addr_locked), .reg_pointer(reg_pointer),
   .wr_strobe(wr_strobe)
);

// ### test/sbsp_master.sv
`timescale 1ns/1ps
module sbsp_master (
   input logic ref_clk,
   input logic sda_oe,
   input logic sda_out,
   output logic scl,
   output logic sda
);
   // ------------------------------------------------------------
   // Bus master model
   // ------------------------------------------------------------
   logic sda_r = 1'b1;
   logic scl_r = 1'b1;
   assign scl = scl_r;
   // Released line goes to the pull-up level
   assign sda = sda_r & ~(sda_oe & ~sda_out);
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : w
   // Start is frame(1,0,0), stop is frame(0,1,1)
   task automatic frame(input logic a, input logic b, input logic c);
      w(5);
      sda_r <= a;
      w(5);
      scl_r <= 1'b1;
      w(5);
      sda_r <= b;
      w(5);
      scl_r <= c;
   endtask : frame
   // Low phase stretched so the slave answer settles first
   task automatic bit_x(input logic b, output logic s);
      w(5);
      sda_r <= b;
      w(5);
      scl_r <= 1'b1;
      w(3);
      s = sda;
      w(2);
      scl_r <= 1'b0;
   endtask : bit_x
   // Ninth clock always released: slave ack or master nack
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ak);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(1'b1, ak);
   endtask : xfer
endmodule : sbsp_master

// ### test/sbsp_slave_bench.sv
`timescale 1ns/1ps
module sbsp_slave_bench;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic strap_en = 1'b1, strap_sel = 1'b0, tmo_dis = 1'b0, fan3_lvl = 1'b1;
   logic scl, sda, sda_out, sda_oe, fan3_out, fan3_oe, fan4, locked, wr_stb;
   logic [6:0] slave_addr;
   logic [7:0] reg_pointer, wr_data, last_wd, q;
   logic k0, k1, k2, k3;
   int fail_count = 0, samples_checked = 0, n_st = 0;
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (wr_stb === 1'b1) begin
         n_st++;
         last_wd <= wr_data;
      end
   end
   sbsp_slave #(.TIMEOUT_CYC(2000)) u_sbsp_slave (
      .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .strap_enable_in(strap_en),
      .strap_select_in(strap_sel), .bus_timeout_disable(tmo_dis),
      .fan3_drive_level(fan3_lvl), .fan3_drive_output(fan3_out),
      .fan3_drive_oe(fan3_oe), .fan4_speed_sense(fan4),
      .slave_addr(slave_addr), .addr_locked(locked),
      .reg_pointer(reg_pointer), .wr_strobe(wr_stb), .wr_data(wr_data)
   );
   sbsp_master u_sbsp_master (.ref_clk(ref_clk), .sda_oe(sda_oe),
      .sda_out(sda_out), .scl(scl), .sda(sda));
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : w
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic rst(input logic en, input logic sel);
      reset_n <= 1'b0;
      strap_en <= en;
      strap_sel <= sel;
      w(5);
      reset_n <= 1'b1;
      w(5);
   endtask : rst
   task automatic s_addr;
      logic [6:0] a;
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 7'h2E : {5'h0B, 1'b0, i == 2};
         rst(i == 0, i == 2);
         chk(8'(fan4), 8'h00);
         u_sbsp_master.frame(1'b1, 1'b0, 1'b0);
         u_sbsp_master.xfer({a, 1'b0}, q, k0);
         u_sbsp_master.frame(1'b0, 1'b1, 1'b1);
         strap_en <= ~strap_en;
         strap_sel <= ~strap_sel;
         w(10);
         chk(8'(k0), 8'h00);
         chk(8'(locked), 8'h01);
         chk(8'(slave_addr), 8'(a));
      end
   endtask : s_addr
   task automatic s_wr;
      n_st = 0;
      u_sbsp_master.frame(1'b1, 1'b0, 1'b0);
      u_sbsp_master.xfer({7'h2E, 1'b0}, q, k0);
      u_sbsp_master.xfer(8'h05, q, k1);
      u_sbsp_master.xfer(8'hA5, q, k2);
      u_sbsp_master.xfer(8'h3C, q, k3);
      u_sbsp_master.frame(1'b0, 1'b1, 1'b1);
      chk(8'({k0, k1, k2, k3}), 8'h01);
      chk(reg_pointer, 8'h05);
      chk(8'(n_st), 8'h01);
      chk(last_wd, 8'hA5);
   endtask : s_wr
   task automatic s_fan;
      fan3_lvl <= 1'b0;
      strap_sel <= 1'b1;
      w(10);
      chk(8'({fan3_oe, fan4}), 8'h03);
      fan3_lvl <= 1'b1;
      strap_sel <= 1'b0;
      w(10);
      chk(8'({fan3_oe, fan4}), 8'h00);
   endtask : s_fan
   task automatic s_rd;
      for (int j = 0; j < 3; j++) begin
         u_sbsp_master.frame(1'b1, 1'b0, 1'b0);
         if (j < 2) begin
            u_sbsp_master.xfer({7'h2E, 1'b0}, q, k0);
            u_sbsp_master.xfer(8'(6 - j), q, k1);
            u_sbsp_master.frame(1'b1, 1'b0, 1'b0);
         end
         u_sbsp_master.xfer({7'h2E, 1'b1}, q, k2);
         u_sbsp_master.xfer(8'hFF, q, k3);
         u_sbsp_master.frame(1'b0, 1'b1, 1'b1);
         chk(8'({k0, k1, k2, k3}), 8'h01);
         chk(q, (j == 0) ? 8'h00 : 8'hA5);
      end
      chk(reg_pointer, 8'h05);
   endtask : s_rd
   task automatic s_foreign;
      u_sbsp_master.frame(1'b1, 1'b0, 1'b0);
      u_sbsp_master.xfer({7'h2F, 1'b0}, q, k0);
      u_sbsp_master.frame(1'b1, 1'b0, 1'b0);
      u_sbsp_master.xfer({7'h2D, 1'b1}, q, k1);
      u_sbsp_master.frame(1'b0, 1'b1, 1'b1);
      chk(8'({k0, k1}), 8'h03);
   endtask : s_foreign
   // Ack left standing with SCL held low
   task automatic s_tmo;
      for (int j = 1; j >= 0; j--) begin
         tmo_dis <= 1'(j);
         q = {7'h2E, 1'b0};
         u_sbsp_master.frame(1'b1, 1'b0, 1'b0);
         for (int i = 7; i >= 0; i--) u_sbsp_master.bit_x(q[i], k1);
         w(20);
         chk(8'(sda_oe), 8'h01);
         w(2100);
         chk(8'(sda_oe), 8'(j));
         rst(1'b1, 1'b0);
      end
   endtask : s_tmo
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   initial begin
      rst(1'b1, 1'b0);
      s_addr;
      rst(1'b1, 1'b0);
      s_wr;
      s_fan;
      s_rd;
      s_foreign;
      s_tmo;
      print_verdict;
   end
   initial begin
      w(30000);
      fail_count++;
      print_verdict;
   end
endmodule : sbsp_slave_bench
